//--- src/bru_consts.svh
`ifndef BRU_CONSTS_SVH
`define BRU_CONSTS_SVH

// ****************************************
// Opcode field layout
// ****************************************
`define BRU_OPC_HI 15
`define BRU_OPC_LO 10
`define BRU_DEST_BIT 9
`define BRU_BANK_BIT 8
`define BRU_OPC_ROT_LEFT 6'h11
`define BRU_OPC_ROT_RIGHT 6'h0c

// ****************************************
// Address resolution
// ****************************************
`define BRU_ACCESS_LIMIT 8'h5f
`define BRU_ACCESS_LOW_BANK 4'h0
`define BRU_ACCESS_HIGH_BANK 4'hf

// ****************************************
// Reset values
// ****************************************
`define BRU_RST_ADDR 12'h000
`define BRU_RST_BYTE 8'h00

`endif

//--- src/bru_pkg.sv
package bru_pkg;

  // One-hot sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } bru_state_t;

  // Decoded operation
  typedef enum logic [1:0] {
    OP_NONE  = 2'h0,
    OP_LEFT  = 2'h1,
    OP_RIGHT = 2'h2
  } bru_op_t;

endpackage

//--- src/bru_rotator.sv
`timescale 1ns/1ns

// ****************************************
// Single-position byte rotator
// ****************************************
module bru_rotator (
  input wire logic [7:0] i_data,
  input wire logic i_carry,
  input wire logic i_right,
  output logic [7:0] o_result,
  output logic o_carry
);

  // Left wraps bit 7 round and keeps carry; right goes through carry
  always_comb begin
    if (i_right) begin
      o_result = {i_carry, i_data[7:1]};
      o_carry = i_data[0];
    end else begin
      o_result = {i_data[6:0], i_data[7]};
      o_carry = i_carry;
    end
  end

endmodule

//--- src/bru_top.sv
`timescale 1ns/1ns
`include "bru_consts.svh"

module bru_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  input wire logic [15:0] i_instr,
  input wire logic i_ext_en,
  input wire logic [3:0] i_bank_selector,
  input wire logic [11:0] i_index_base,
  input wire logic i_carry,
  input wire logic [7:0] i_mem_rdata,
  output logic o_busy,
  output logic o_done,
  output logic [11:0] o_mem_addr,
  output logic o_mem_rd,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  output logic o_acc_we,
  output logic [7:0] o_acc_wdata,
  output logic o_carry_we,
  output logic o_carry,
  output logic o_nz_we,
  output logic o_neg,
  output logic o_zero
);
  import bru_pkg::*;

  // ****************************************
  // Decode helpers
  // ****************************************

  // Opcode to operation, shared by issue and capture
  function automatic bru_op_t decode_op(input logic [15:0] instr);
    logic [5:0] opc;
    opc = instr[`BRU_OPC_HI:`BRU_OPC_LO];
    if (opc == `BRU_OPC_ROT_LEFT) begin
      decode_op = OP_LEFT;
    end else if (opc == `BRU_OPC_ROT_RIGHT) begin
      decode_op = OP_RIGHT;
    end else begin
      decode_op = OP_NONE;
    end
  endfunction

  // Operand address from field, bank-access bit and mode
  function automatic logic [11:0] resolve_addr(input logic [7:0] f, input logic bank_bit,
                                               input logic ext, input logic [3:0] bsel,
                                               input logic [11:0] base);
    logic low;
    low = (f <= `BRU_ACCESS_LIMIT);
    if (bank_bit) begin
      resolve_addr = {bsel, f};
    end else if (ext && low) begin
      resolve_addr = 12'(base + {4'h0, f});
    end else if (low) begin
      resolve_addr = {`BRU_ACCESS_LOW_BANK, f};
    end else begin
      resolve_addr = {`BRU_ACCESS_HIGH_BANK, f};
    end
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  bru_state_t state_q;
  bru_op_t op_q;
  logic dest_q;
  logic cin_q;
  logic [7:0] data_q;
  logic issue;
  logic [7:0] rot_result;
  logic rot_carry;

  // Unknown opcodes are simply not taken; the core decodes elsewhere
  assign issue = (state_q == ST_IDLE) && i_valid && (decode_op(i_instr) != OP_NONE);

  // Idle, read the operand, then write the destination
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else if (i_ce) begin
      case (state_q)
        ST_IDLE: begin
          if (issue) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          state_q <= ST_WRITE;
        end
        ST_WRITE: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Latch instruction fields at issue
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      op_q <= OP_NONE;
      dest_q <= 1'b1;
      o_mem_addr <= `BRU_RST_ADDR;
    end else if (i_ce && issue) begin
      op_q <= decode_op(i_instr);
      dest_q <= i_instr[`BRU_DEST_BIT];
      o_mem_addr <= resolve_addr(i_instr[7:0], i_instr[`BRU_BANK_BIT], i_ext_en,
                                 i_bank_selector, i_index_base);
    end
  end

  // Read strobe and busy; busy covers the whole sequence
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_rd <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_mem_rd <= issue;
      o_busy <= issue || (state_q == ST_READ);
    end
  end

  // Operand and carry sampled while the read strobe is out
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= `BRU_RST_BYTE;
      cin_q <= 1'b0;
    end else if (i_ce && state_q == ST_READ) begin
      data_q <= i_mem_rdata;
      cin_q <= i_carry;
    end
  end

  // ****************************************
  // Datapath and write-back
  // ****************************************
  bru_rotator u_rot (
    .i_data(i_mem_rdata),
    .i_carry(i_carry),
    .i_right(op_q == OP_RIGHT),
    .o_result(rot_result),
    .o_carry(rot_carry)
  );

  // Result steered to memory or accumulator, one-cycle strobes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_we <= 1'b0;
      o_mem_wdata <= `BRU_RST_BYTE;
      o_acc_we <= 1'b0;
      o_acc_wdata <= `BRU_RST_BYTE;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= (state_q == ST_READ);
      o_mem_we <= (state_q == ST_READ) && dest_q;
      o_acc_we <= (state_q == ST_READ) && !dest_q;
      if (state_q == ST_READ) begin
        o_mem_wdata <= rot_result;
        o_acc_wdata <= rot_result;
      end
    end
  end

  // Status flags; carry only written by the right rotate
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_carry_we <= 1'b0;
      o_carry <= 1'b0;
      o_nz_we <= 1'b0;
      o_neg <= 1'b0;
      o_zero <= 1'b0;
    end else if (i_ce) begin
      o_carry_we <= (state_q == ST_READ) && (op_q == OP_RIGHT);
      o_nz_we <= (state_q == ST_READ);
      if (state_q == ST_READ) begin
        o_carry <= rot_carry;
        o_neg <= rot_result[7];
        o_zero <= (rot_result == 8'h00);
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [7:0] wres;
  assign wres = dest_q ? o_mem_wdata : o_acc_wdata;

  property p_left_rotate;
    @(posedge i_clk) disable iff (i_rst)
    (o_done && op_q == OP_LEFT) |-> wres == {data_q[6:0], data_q[7]};
  endproperty
  a_left_rotate: assert property (p_left_rotate) else $error("left rotate wrong");

  property p_right_rotate;
    @(posedge i_clk) disable iff (i_rst)
    (o_done && op_q == OP_RIGHT) |-> wres == {cin_q, data_q[7:1]} && o_carry == data_q[0]
      && o_carry_we;
  endproperty
  a_right_rotate: assert property (p_right_rotate) else $error("right rotate wrong");

  property p_dest_acc;
    @(posedge i_clk) disable iff (i_rst)
    (o_done && !dest_q) |-> o_acc_we && !o_mem_we;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("accumulator write wrong");

  property p_dest_mem;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && issue && i_instr[`BRU_DEST_BIT]) ##1 i_ce |=> o_mem_we && !o_acc_we
      && $stable(o_mem_addr);
  endproperty
  a_dest_mem: assert property (p_dest_mem) else $error("memory write-back wrong");

  property p_access_bank;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && issue && !i_instr[`BRU_BANK_BIT]
      && !(i_ext_en && i_instr[7:0] <= `BRU_ACCESS_LIMIT))
      |=> o_mem_addr[7:0] == $past(i_instr[7:0]) && o_mem_addr[11:8] ==
        (o_mem_addr[7:0] <= `BRU_ACCESS_LIMIT ? `BRU_ACCESS_LOW_BANK : `BRU_ACCESS_HIGH_BANK);
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");

  property p_banked;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && issue && i_instr[`BRU_BANK_BIT])
      |=> o_mem_addr == {$past(i_bank_selector), $past(i_instr[7:0])} && o_mem_rd;
  endproperty
  a_banked: assert property (p_banked) else $error("banked address wrong");

  property p_indexed;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && issue && !i_instr[`BRU_BANK_BIT] && i_ext_en
      && i_instr[7:0] <= `BRU_ACCESS_LIMIT)
      |=> o_mem_addr == 12'($past(i_index_base) + {4'h0, $past(i_instr[7:0])});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_left_flags;
    @(posedge i_clk) disable iff (i_rst)
    (o_done && op_q == OP_LEFT) |-> !o_carry_we && o_nz_we && o_neg == wres[7]
      && o_zero == (wres == 8'h00);
  endproperty
  a_left_flags: assert property (p_left_flags) else $error("left rotate flags wrong");

endmodule

//--- verification/byte_rotate_instruction_unit_tb_top.sv
`timescale 1ns/1ns
`include "bru_consts.svh"

// One compare: count it, report a mismatch at once
`define CHK(n, a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end

module byte_rotate_instruction_unit_tb_top;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_valid = 1'b0;
  logic i_ce = 1'b1;
  logic i_ext_en = 1'b0;
  logic i_carry = 1'b0;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0] i_bank_selector = 4'h0;
  logic [11:0] i_index_base = 12'h000;
  logic [7:0] i_mem_rdata = 8'h00;
  logic o_busy, o_done, o_mem_rd, o_mem_we, o_acc_we, o_carry_we, o_carry;
  logic o_nz_we, o_neg, o_zero;
  logic [11:0] o_mem_addr;
  logic [7:0] o_mem_wdata, o_acc_wdata;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  bru_top i_bru_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_valid(i_valid), .i_instr(i_instr),
    .i_ext_en(i_ext_en), .i_bank_selector(i_bank_selector), .i_index_base(i_index_base),
    .i_carry(i_carry), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_done(o_done),
    .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .o_mem_we(o_mem_we),
    .o_mem_wdata(o_mem_wdata), .o_acc_we(o_acc_we), .o_acc_wdata(o_acc_wdata),
    .o_carry_we(o_carry_we), .o_carry(o_carry), .o_nz_we(o_nz_we), .o_neg(o_neg),
    .o_zero(o_zero)
  );

  // ****************************************
  // Clock, timeout and closing report
  // ****************************************
  initial begin
    forever #4 i_clk = ~i_clk;
  end

  // Whole run needs about 70 cycles; a hang ends here
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // One instruction, end to end
  // ****************************************
  // Memory data and carry are set with the request, so they are stable in the read cycle
  task automatic do_op(input logic r, input logic d, input logic a, input logic [7:0] f,
                       input logic ext, input logic [3:0] bsel, input logic [11:0] base,
                       input logic [7:0] rd, input logic c, input logic [11:0] ea);
    logic [7:0] res;
    logic nc;
    res = r ? {c, rd[7:1]} : {rd[6:0], rd[7]};
    nc = r ? rd[0] : c;
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= {r ? `BRU_OPC_ROT_RIGHT : `BRU_OPC_ROT_LEFT, d, a, f};
    i_ext_en <= ext;
    i_bank_selector <= bsel;
    i_index_base <= base;
    i_mem_rdata <= rd;
    i_carry <= c;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    `CHK("read", {o_mem_rd, o_busy}, 2'b11)
    `CHK("addr", o_mem_addr, ea)
    @(posedge i_clk);
    #1;
    `CHK("pulses", {o_done, o_mem_rd, o_mem_we, o_acc_we}, {1'b1, 1'b0, d, ~d})
    `CHK("flag_we", {o_carry_we, o_nz_we}, {r, 1'b1})
    `CHK("result", d ? o_mem_wdata : o_acc_wdata, res)
    `CHK("flags", {o_carry, o_neg, o_zero}, {nc, res[7], res == 8'h00})
    // Every strobe lasts one cycle only
    @(posedge i_clk);
    #1;
    `CHK("idle", {o_busy, o_done, o_mem_we, o_acc_we, o_carry_we, o_nz_we}, 6'h00)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Left rotate, wrap of bit 7, zero result, banked address
  task automatic t_left();
    do_op(1'b0, 1'b1, 1'b1, 8'h25, 1'b0, 4'h3, 12'h000, 8'hab, 1'b1, 12'h325);
    do_op(1'b0, 1'b0, 1'b1, 8'hff, 1'b1, 4'hc, 12'h123, 8'h80, 1'b0, 12'hcff);
    do_op(1'b0, 1'b1, 1'b1, 8'h00, 1'b0, 4'hf, 12'h000, 8'h00, 1'b1, 12'hf00);
  endtask

  // Right rotate through carry, both carry directions
  task automatic t_right();
    do_op(1'b1, 1'b0, 1'b1, 8'h10, 1'b0, 4'h1, 12'h000, 8'he6, 1'b0, 12'h110);
    do_op(1'b1, 1'b1, 1'b1, 8'h01, 1'b0, 4'h2, 12'h000, 8'h01, 1'b1, 12'h201);
    do_op(1'b1, 1'b0, 1'b1, 8'h02, 1'b0, 4'h2, 12'h000, 8'h01, 1'b0, 12'h202);
  endtask

  // Access bank edges, bank selector must be ignored
  task automatic t_access();
    do_op(1'b0, 1'b1, 1'b0, 8'h5f, 1'b0, 4'h7, 12'h000, 8'h11, 1'b0, 12'h05f);
    do_op(1'b1, 1'b1, 1'b0, 8'h60, 1'b0, 4'h7, 12'h000, 8'h22, 1'b1, 12'hf60);
  endtask

  // Unknown opcode is not taken: no read strobe, never busy
  task automatic t_refused();
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= 16'h0000;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
    `CHK("unknown", {o_mem_rd, o_busy}, 2'b00)
  endtask

  // Clock enable low in the read cycle holds every state and strobe
  task automatic t_freeze();
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= {`BRU_OPC_ROT_LEFT, 1'b1, 1'b1, 8'h40};
    i_bank_selector <= 4'h2;
    i_mem_rdata <= 8'h81;
    i_carry <= 1'b0;
    @(posedge i_clk);
    i_valid <= 1'b0;
    i_ce <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("frozen", {o_mem_rd, o_busy, o_done, o_mem_addr}, {3'b110, 12'h240})
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(posedge i_clk);
    #1;
    `CHK("thawed", {o_done, o_mem_we, o_mem_wdata}, {2'b11, 8'h03})
  endtask

  // Reset in mid-sequence drops every strobe and the address
  task automatic t_reset();
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= {`BRU_OPC_ROT_RIGHT, 1'b0, 1'b1, 8'h33};
    @(posedge i_clk);
    i_valid <= 1'b0;
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    `CHK("reset", {o_mem_rd, o_busy, o_done, o_mem_addr}, 15'h0000)
  endtask

  // Indexed offset at the limit, with wrap, and just above it
  task automatic t_indexed();
    do_op(1'b0, 1'b1, 1'b0, 8'h5f, 1'b1, 4'h5, 12'hff0, 8'h3c, 1'b0, 12'h04f);
    do_op(1'b1, 1'b0, 1'b0, 8'h00, 1'b1, 4'h5, 12'h234, 8'h3c, 1'b1, 12'h234);
    do_op(1'b0, 1'b1, 1'b0, 8'h60, 1'b1, 4'h5, 12'h234, 8'h3c, 1'b0, 12'hf60);
    do_op(1'b0, 1'b1, 1'b1, 8'h10, 1'b1, 4'h5, 12'h234, 8'h3c, 1'b0, 12'h510);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_left();
    t_right();
    t_access();
    t_refused();
    t_freeze();
    t_reset();
    t_indexed();
    end_of_test();
  end
endmodule
